// *** vev_defs.svh ***
// Offsets, field positions, reset values and timing counts of the ejector valve control
`ifndef VEV_DEFS_SVH
`define VEV_DEFS_SVH
`define VEV_ADDR_CTRL     8'h00
`define VEV_ADDR_CUTOFF   8'h04
`define VEV_ADDR_PRESENCE 8'h08
`define VEV_ADDR_BLOWTIME 8'h0C
`define VEV_ADDR_STATUS   8'h10
`define VEV_CTRL_NC       0
`define VEV_CTRL_REG      1
`define VEV_RST_CTRL      2'h1
`define VEV_RST_CUTOFF    10'h3FF
`define VEV_RST_PRESENCE  10'h226
`define VEV_RST_BLOWTIME  11'h000
`define VEV_CUTOFF_MAX    10'h3FF
`define VEV_CLK_NS        100
`define VEV_TICK_US       1000
`define VEV_HOLD_MS       3000
`define VEV_FLASH_MS      250
`define VEV_SETTLE_MS     50
`endif

// *** vev_pkg.sv ***
// Types shared by the ejector valve control
package vev_pkg;
	typedef enum logic {
		VEV_AUTO,
		VEV_MANUAL
	} vev_mode_t;
endpackage : vev_pkg

// *** vev_ctrl.sv ***
// Ejector valve control: suction and blow-off valves, regulation, manual mode, APB registers
`timescale 1ns/1ps
`include "vev_defs.svh"
module vev_ctrl
	import vev_pkg::*;
#(
	parameter int TICK_CYC = `VEV_TICK_US * 1000 / `VEV_CLK_NS
) (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        suctionCmd,
	input  wire logic        blowCmd,
	input  wire logic        keyUp,
	input  wire logic        keyDown,
	input  wire logic        keyCentre,
	input  wire logic [9:0]  vacuumLevel,
	output logic             suctionValve,
	output logic             blowValve,
	output logic             ledCutoff,
	output logic             ledPresence,
	output logic [9:0]       barLevel,
	output logic             manualMode,
	output logic             valveProtEn
);
	localparam int HOLD_TICKS  = `VEV_HOLD_MS * 1000 / `VEV_TICK_US;
	localparam int FLASH_TICKS = `VEV_FLASH_MS * 1000 / `VEV_TICK_US;

	// Two-stage synchronisers for the command, key and vacuum pins
	logic [4:0] pinMeta_r;
	logic [4:0] pinSync_r;
	logic [4:0] pinPrev_r;
	logic [9:0] vacMeta_r;
	logic [9:0] vacSync_r;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pinMeta_r <= 5'h00;
			pinSync_r <= 5'h00;
			pinPrev_r <= 5'h00;
			vacMeta_r <= 10'h000;
			vacSync_r <= 10'h000;
		end else begin
			pinMeta_r <= {keyCentre, keyDown, keyUp, blowCmd, suctionCmd};
			pinSync_r <= pinMeta_r;
			pinPrev_r <= pinSync_r;
			vacMeta_r <= vacuumLevel;
			vacSync_r <= vacMeta_r;
		end
	end
	wire logic sCmd = pinSync_r[0];
	wire logic bCmd = pinSync_r[1];
	wire logic up = pinSync_r[2];
	wire logic down = pinSync_r[3];
	wire logic [4:0] pinRise = pinSync_r & ~pinPrev_r;
	wire logic extChange = (pinSync_r[1:0] != pinPrev_r[1:0]);

	// APB slave: one wait state, answer registered
	logic [1:0]  ctrl_r, ctrl_nxt;
	logic [9:0]  cutoff_r, cutoff_nxt;
	logic [9:0]  presence_r, presence_nxt;
	logic [10:0] blowTime_r, blowTime_nxt;
	logic        pready_r, pready_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic        pslverr_r, pslverr_nxt;
	vev_mode_t   mode_r, mode_nxt;
	logic        suctionValve_r, blowValve_r;
	logic        ledCutoff_r, ledPresence_r;

	function automatic logic vevMapped(input logic [7:0] a);
		vevMapped = (a == `VEV_ADDR_CTRL) || (a == `VEV_ADDR_CUTOFF) || (a == `VEV_ADDR_PRESENCE) ||
			(a == `VEV_ADDR_BLOWTIME) || (a == `VEV_ADDR_STATUS);
	endfunction : vevMapped

	always_comb begin
		ctrl_nxt     = ctrl_r;
		cutoff_nxt   = cutoff_r;
		presence_nxt = presence_r;
		blowTime_nxt = blowTime_r;
		pready_nxt   = 1'b0;
		prdata_nxt   = prdata_r;
		pslverr_nxt  = 1'b0;
		if (psel && penable && !pready_r) begin
			pready_nxt  = 1'b1;
			pslverr_nxt = !vevMapped(paddr);
			case (paddr)
				`VEV_ADDR_CTRL:     prdata_nxt = {30'h0000_0000, ctrl_r};
				`VEV_ADDR_CUTOFF:   prdata_nxt = {22'h00_0000, cutoff_r};
				`VEV_ADDR_PRESENCE: prdata_nxt = {22'h00_0000, presence_r};
				`VEV_ADDR_BLOWTIME: prdata_nxt = {21'h00_0000, blowTime_r};
				`VEV_ADDR_STATUS:   prdata_nxt = {26'h000_0000, mode_r == VEV_MANUAL, ledPresence_r,
					ledCutoff_r, blowValve_r, suctionValve_r, blowTime_r != 11'h000};
				default:            prdata_nxt = 32'h0000_0000;
			endcase
		end
		// Writes during manual mode are dropped, not queued
		if (psel && penable && pready_r && pwrite && mode_r == VEV_AUTO) begin
			case (paddr)
				`VEV_ADDR_CTRL:     ctrl_nxt = pwdata[1:0];
				`VEV_ADDR_CUTOFF:   cutoff_nxt = pwdata[9:0];
				`VEV_ADDR_PRESENCE: presence_nxt = pwdata[9:0];
				`VEV_ADDR_BLOWTIME: blowTime_nxt = pwdata[10:0];
				default:            ctrl_nxt = ctrl_r;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_r     <= `VEV_RST_CTRL;
			cutoff_r   <= `VEV_RST_CUTOFF;
			presence_r <= `VEV_RST_PRESENCE;
			blowTime_r <= `VEV_RST_BLOWTIME;
			pready_r   <= 1'b0;
			prdata_r   <= 32'h0000_0000;
			pslverr_r  <= 1'b0;
		end else begin
			ctrl_r     <= ctrl_nxt;
			cutoff_r   <= cutoff_nxt;
			presence_r <= presence_nxt;
			blowTime_r <= blowTime_nxt;
			pready_r   <= pready_nxt;
			prdata_r   <= prdata_nxt;
			pslverr_r  <= pslverr_nxt;
		end
	end

	// Millisecond tick shared by all timers
	logic [13:0] tickCnt_r, tickCnt_nxt;
	logic        tick_r, tick_nxt;
	always_comb begin
		tick_nxt    = (tickCnt_r == 14'(TICK_CYC - 1));
		tickCnt_nxt = tick_nxt ? 14'h0000 : tickCnt_r + 14'h0001;
	end

	// Valve and mode control
	logic [11:0] holdCnt_r, holdCnt_nxt;
	logic [10:0] blowCnt_r, blowCnt_nxt;
	logic [7:0]  flashCnt_r, flashCnt_nxt;
	logic        flash_r, flash_nxt;
	logic        manSuck_r, manSuck_nxt;
	logic        regOff_r, regOff_nxt;
	logic        demandPrev_r;
	logic        suctionValve_nxt, blowValve_nxt;
	logic        ledCutoff_nxt, ledPresence_nxt;
	logic [9:0]  barLevel_r;
	logic        manualMode_r, valveProtEn_r;
	logic        demand, timedMode, regActive, manBlow, blowOn;
	logic [9:0]  resumeLevel;

	always_comb begin
		mode_nxt     = mode_r;
		holdCnt_nxt  = holdCnt_r;
		manSuck_nxt  = manSuck_r;
		flashCnt_nxt = flashCnt_r;
		flash_nxt    = flash_r;
		if (ctrl_r[`VEV_CTRL_NC])
			demand = sCmd;
		else
			demand = !sCmd;
		timedMode   = (blowTime_r != 11'h000);
		regActive   = ctrl_r[`VEV_CTRL_REG] && (cutoff_r != `VEV_CUTOFF_MAX);
		resumeLevel = cutoff_r - 10'(cutoff_r / 10'd5);
		manBlow     = 1'b0;
		if (mode_r == VEV_AUTO) begin
			if ((up || down) && tick_r)
				holdCnt_nxt = holdCnt_r + 12'h001;
			else if (!(up || down))
				holdCnt_nxt = 12'h000;
			if (holdCnt_r > 12'(HOLD_TICKS)) begin
				mode_nxt    = VEV_MANUAL;
				manSuck_nxt = 1'b0;
			end
		end else begin
			// Keys are accepted only after the entry key is let go
			if (holdCnt_r == 12'h000 && pinRise[2] && !manSuck_r)
				manSuck_nxt = 1'b1;
			else if (holdCnt_r == 12'h000 && (pinRise[2] || pinRise[3]))
				manSuck_nxt = 1'b0;
			if (!(up || down))
				holdCnt_nxt = 12'h000;
			manBlow = down && holdCnt_r == 12'h000 && !manSuck_r;
			if (pinRise[4] || extChange) begin
				mode_nxt    = VEV_AUTO;
				manSuck_nxt = 1'b0;
				// A key still held on exit must not count towards a new entry
				holdCnt_nxt = 12'h000;
			end
			if (tick_r) begin
				if (flashCnt_r == 8'(FLASH_TICKS - 1)) begin
					flashCnt_nxt = 8'h00;
					flash_nxt    = !flash_r;
				end else begin
					flashCnt_nxt = flashCnt_r + 8'h01;
				end
			end
		end
		if (mode_r == VEV_MANUAL)
			demand = manSuck_r;
		// Hysteresis state, kept in manual suction as well
		regOff_nxt = regOff_r;
		if (!demand || !regActive)
			regOff_nxt = 1'b0;
		else if (vacSync_r >= cutoff_r)
			regOff_nxt = 1'b1;
		else if (vacSync_r < resumeLevel)
			regOff_nxt = 1'b0;
		blowCnt_nxt = blowCnt_r;
		if (mode_r == VEV_AUTO && timedMode && demandPrev_r && !demand)
			blowCnt_nxt = blowTime_r;
		else if (demand || mode_r == VEV_MANUAL)
			blowCnt_nxt = 11'h000;
		else if (tick_r && blowCnt_r != 11'h000)
			blowCnt_nxt = blowCnt_r - 11'h001;
		if (mode_r == VEV_MANUAL)
			blowOn = manBlow;
		else if (timedMode)
			blowOn = (blowCnt_r != 11'h000);
		else
			blowOn = bCmd;
		blowValve_nxt    = blowOn;
		// Next hysteresis state, so the nozzle stops in the cycle the cutoff is seen
		suctionValve_nxt = demand && !regOff_nxt && !blowOn;
		if (mode_r == VEV_MANUAL) begin
			ledCutoff_nxt   = manBlow || flash_r;
			ledPresence_nxt = manBlow || flash_r;
		end else begin
			ledCutoff_nxt   = regActive && vacSync_r >= cutoff_r;
			ledPresence_nxt = vacSync_r >= presence_r;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			tickCnt_r      <= 14'h0000;
			tick_r         <= 1'b0;
			mode_r         <= VEV_AUTO;
			holdCnt_r      <= 12'h000;
			blowCnt_r      <= 11'h000;
			flashCnt_r     <= 8'h00;
			flash_r        <= 1'b0;
			manSuck_r      <= 1'b0;
			regOff_r       <= 1'b0;
			demandPrev_r   <= 1'b0;
			suctionValve_r <= 1'b0;
			blowValve_r    <= 1'b0;
			ledCutoff_r    <= 1'b0;
			ledPresence_r  <= 1'b0;
			barLevel_r     <= 10'h000;
			manualMode_r   <= 1'b0;
			valveProtEn_r  <= 1'b1;
		end else begin
			tickCnt_r      <= tickCnt_nxt;
			tick_r         <= tick_nxt;
			mode_r         <= mode_nxt;
			holdCnt_r      <= holdCnt_nxt;
			blowCnt_r      <= blowCnt_nxt;
			flashCnt_r     <= flashCnt_nxt;
			flash_r        <= flash_nxt;
			manSuck_r      <= manSuck_nxt;
			regOff_r       <= regOff_nxt;
			demandPrev_r   <= demand;
			suctionValve_r <= suctionValve_nxt;
			blowValve_r    <= blowValve_nxt;
			ledCutoff_r    <= ledCutoff_nxt;
			ledPresence_r  <= ledPresence_nxt;
			barLevel_r     <= vacSync_r;
			manualMode_r   <= (mode_nxt == VEV_MANUAL);
			valveProtEn_r  <= (mode_nxt == VEV_AUTO);
		end
	end

	assign pready       = pready_r;
	assign prdata       = prdata_r;
	assign pslverr      = pslverr_r;
	assign suctionValve = suctionValve_r;
	assign blowValve    = blowValve_r;
	assign ledCutoff    = ledCutoff_r;
	assign ledPresence  = ledPresence_r;
	assign barLevel     = barLevel_r;
	assign manualMode   = manualMode_r;
	assign valveProtEn  = valveProtEn_r;
endmodule : vev_ctrl

// *** vev_ctrl_sva.sv ***
// Port assertions of the ejector valve control
`timescale 1ns/1ps
module vev_ctrl_sva #(
	parameter int TICK_CYC = 10
) (
	input wire logic       mclk,
	input wire logic       rst_b,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic       suctionCmd,
	input wire logic       keyUp,
	input wire logic       keyDown,
	input wire logic [9:0] vacuumLevel,
	input wire logic       suctionValve,
	input wire logic       blowValve,
	input wire logic [9:0] barLevel,
	input wire logic       manualMode,
	input wire logic       valveProtEn
);
	logic [2:0] upCnt_r;
	logic [2:0] upCnt_nxt;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// Sync flops hold reset values for a few edges, so the bar is judged later
	always_comb begin
		upCnt_nxt = (upCnt_r == 3'h7) ? upCnt_r : upCnt_r + 3'h1;
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			upCnt_r <= 3'h0;
		end else begin
			upCnt_r <= upCnt_nxt;
		end
	end
	a_blow_no_suck: assert property (blowValve |-> !suctionValve)
		else $error("suction runs during blow-off");
	a_prot_off_manual: assert property (valveProtEn == !manualMode)
		else $error("valve protection wrong for mode");
	a_manual_after_hold: assert property ($rose(manualMode) |-> $past(keyUp || keyDown, 3))
		else $error("manual mode entered without key held");
	a_manual_ext_leave: assert property (manualMode && $changed(suctionCmd) |-> ##[1:5] !manualMode)
		else $error("manual mode kept after input change");
	a_bar_shows_vac: assert property (
		(upCnt_r == 3'h7 && $stable(vacuumLevel))[*4] |-> barLevel == vacuumLevel)
		else $error("bar does not show vacuum");
	a_apb_one_wait: assert property (psel && $rose(penable) |=> pready)
		else $error("answer not after one wait state");
	a_apb_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_apb_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
endmodule : vev_ctrl_sva
bind vev_ctrl vev_ctrl_sva #(.TICK_CYC(TICK_CYC)) i_sva (
	.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .suctionCmd(suctionCmd), .keyUp(keyUp), .keyDown(keyDown),
	.vacuumLevel(vacuumLevel), .suctionValve(suctionValve), .blowValve(blowValve),
	.barLevel(barLevel), .manualMode(manualMode), .valveProtEn(valveProtEn)
);

// *** vev_host_model.sv ***
// Machine controller model driving the suction and blow-off commands
`timescale 1ns/1ps
module vev_host_model (
	input  wire logic mclk,
	input  wire logic rst_b,
	input  wire logic wantSuck,
	input  wire logic wantBlow,
	input  wire logic settleHold,
	output logic      suctionCmd,
	output logic      blowCmd
);
	logic suck_r, suck_nxt, blow_r, blow_nxt;
	// Commands freeze while a setting is being applied
	always_comb begin
		suck_nxt = settleHold ? suck_r : wantSuck;
		blow_nxt = settleHold ? blow_r : wantBlow;
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			suck_r <= 1'h0;
			blow_r <= 1'h0;
		end else begin
			suck_r <= suck_nxt;
			blow_r <= blow_nxt;
		end
	end
	assign suctionCmd = suck_r;
	assign blowCmd = blow_r;
endmodule : vev_host_model

// *** vacuum_ejector_valve_control_test.sv ***
// Self-checking testbench of the ejector valve control
`timescale 1ns/1ps
`include "vev_defs.svh"
module vacuum_ejector_valve_control_test
	import vev_pkg::*;
;
	localparam int TC = 10;
	logic mclk, rst_b, psel, penable, pwrite, pready, pslverr, er, wantSuck, wantBlow, settle;
	logic keyUp, keyDown, keyCentre, suctionCmd, blowCmd, suctionValve, blowValve;
	logic ledCutoff, ledPresence, manualMode, valveProtEn;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [9:0]  vacuumLevel, barLevel;
	logic [1:0]  ledSeen;
	int          err_total, check_count;
	vev_ctrl #(.TICK_CYC(TC)) i_dut (
		.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.suctionCmd(suctionCmd), .blowCmd(blowCmd), .keyUp(keyUp), .keyDown(keyDown),
		.keyCentre(keyCentre), .vacuumLevel(vacuumLevel), .suctionValve(suctionValve),
		.blowValve(blowValve), .ledCutoff(ledCutoff), .ledPresence(ledPresence),
		.barLevel(barLevel), .manualMode(manualMode), .valveProtEn(valveProtEn)
	);
	vev_host_model i_host (
		.mclk(mclk), .rst_b(rst_b), .wantSuck(wantSuck), .wantBlow(wantBlow),
		.settleHold(settle), .suctionCmd(suctionCmd), .blowCmd(blowCmd)
	);
	always #50 mclk = ~mclk;
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Request held until pready is sampled high; data taken at that edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		settle <= w;
		@(posedge mclk);
		penable <= 1'h1;
		do @(posedge mclk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		settle <= 1'h0;
		// Idle cycle, so a following call never drives these twice in one step
		@(posedge mclk);
	endtask : apb
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0000_0000);
		chk(nm, e, rd);
	endtask : rdchk
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		cyc(90000);
		err_total++;
		tally_and_finish;
	end
	initial begin
		mclk = 1'h0;
		{rst_b, psel, penable, pwrite, wantSuck, wantBlow, settle, keyUp, keyDown, keyCentre} = '0;
		{paddr, pwdata, vacuumLevel} = '0;
		cyc(4);
		rst_b <= 1'h1;
		rdchk("ctrl", `VEV_ADDR_CTRL, 32'h0000_0001);
		rdchk("cutoff", `VEV_ADDR_CUTOFF, 32'h0000_03FF);
		rdchk("presence", `VEV_ADDR_PRESENCE, 32'h0000_0226);
		rdchk("blowtime", `VEV_ADDR_BLOWTIME, 32'h0000_0000);
		rdchk("status", `VEV_ADDR_STATUS, 32'h0000_0000);
		rdchk("unmapped", 8'h14, 32'h0000_0000);
		chk("slverr", 1, er);
		$display("test registers done");
		wantSuck <= 1'h1;
		cyc(6);
		chk("nc on", 1, suctionValve);
		wantSuck <= 1'h0;
		cyc(6);
		chk("nc off", 0, suctionValve);
		apb(1'h1, `VEV_ADDR_CTRL, 32'h0000_0000);
		cyc(6);
		chk("no idle", 1, suctionValve);
		wantSuck <= 1'h1;
		cyc(6);
		chk("no cmd", 0, suctionValve);
		wantSuck <= 1'h0;
		wantBlow <= 1'h1;
		cyc(6);
		chk("ext blow", 1, blowValve);
		chk("blow suck", 0, suctionValve);
		wantBlow <= 1'h0;
		cyc(6);
		chk("ext end", 0, blowValve);
		$display("test variants done");
		apb(1'h1, `VEV_ADDR_CTRL, 32'h0000_0003);
		apb(1'h1, `VEV_ADDR_CUTOFF, 32'h0000_01F4);
		wantSuck <= 1'h1;
		vacuumLevel <= 10'h1F4;
		cyc(8);
		chk("cutoff", 0, suctionValve);
		chk("bar", 10'h1F4, barLevel);
		chk("led cutoff", 2'h2, {ledCutoff, ledPresence});
		vacuumLevel <= 10'h190;
		cyc(8);
		chk("margin", 0, suctionValve);
		vacuumLevel <= 10'h18F;
		cyc(8);
		chk("resume", 1, suctionValve);
		apb(1'h1, `VEV_ADDR_CUTOFF, 32'h0000_03FF);
		vacuumLevel <= 10'h3FF;
		cyc(8);
		chk("max", 1, suctionValve);
		chk("led max", 2'h1, {ledCutoff, ledPresence});
		wantSuck <= 1'h0;
		vacuumLevel <= 10'h000;
		cyc(6);
		$display("test regulation done");
		apb(1'h1, `VEV_ADDR_BLOWTIME, 32'h0000_0005);
		rdchk("timed", `VEV_ADDR_STATUS, 32'h0000_0001);
		chk("timed bit", 1, rd & 32'h0000_0001);
		wantSuck <= 1'h1;
		cyc(6);
		wantSuck <= 1'h0;
		cyc(8);
		chk("timed on", 1, blowValve);
		cyc(30);
		chk("timed hold", 1, blowValve);
		cyc(40);
		chk("timed end", 0, blowValve);
		apb(1'h1, `VEV_ADDR_BLOWTIME, 32'h0000_0000);
		apb(1'h1, `VEV_ADDR_CUTOFF, 32'h0000_01F4);
		$display("test timed blow done");
		for (int i = 0; i < 2; i++) begin
			if (i == 0) keyUp <= 1'h1;
			else keyDown <= 1'h1;
			cyc(`VEV_HOLD_MS * TC - 30);
			chk("early", 0, manualMode);
			cyc(80);
			chk("manual", 1, manualMode);
			chk("prot", 0, valveProtEn);
			keyUp <= 1'h0;
			keyDown <= 1'h0;
			cyc(6);
			if (i == 0) begin
				apb(1'h1, `VEV_ADDR_BLOWTIME, 32'h0000_0007);
				rdchk("locked", `VEV_ADDR_BLOWTIME, 32'h0000_0000);
				keyUp <= 1'h1;
				cyc(6);
				keyUp <= 1'h0;
				cyc(6);
				chk("man suck", 1, suctionValve);
				vacuumLevel <= 10'h1F4;
				cyc(8);
				chk("man cutoff", 0, suctionValve);
				vacuumLevel <= 10'h000;
				cyc(8);
				chk("man resume", 1, suctionValve);
				keyDown <= 1'h1;
				cyc(6);
				chk("man stop", 0, suctionValve);
				keyDown <= 1'h0;
				cyc(6);
				keyDown <= 1'h1;
				cyc(6);
				chk("man blow", 1, blowValve);
				chk("man leds", 3, {ledCutoff, ledPresence});
				keyDown <= 1'h0;
				cyc(6);
				chk("blow end", 0, blowValve);
				ledSeen = {ledCutoff, ledPresence};
				chk("flash pair", ledSeen[1], ledSeen[0]);
				// One flash half period later both LEDs have toggled once
				cyc(`VEV_FLASH_MS * TC);
				chk("flash", {~ledSeen[1], ~ledSeen[0]}, {ledCutoff, ledPresence});
				keyCentre <= 1'h1;
				cyc(6);
				keyCentre <= 1'h0;
			end else begin
				wantSuck <= 1'h1;
				cyc(6);
				wantSuck <= 1'h0;
			end
			cyc(6);
			chk("auto", 0, manualMode);
			chk("prot back", 1, valveProtEn);
			$display("test manual pass %0d done", i);
		end
		tally_and_finish;
	end
endmodule : vacuum_ejector_valve_control_test
